//--- verilog/sacc_map.vh
`ifndef SACC_MAP_VH
`define SACC_MAP_VH
// result coding
`define SACC_UNI_MID      16'h8000
`define SACC_BIP_MID      16'h0000
`define SACC_UNI_FS_HI    16'hFFFF
`define SACC_UNI_FS_LO    16'h0000
`define SACC_BIP_FS_HI    16'h7FFF
`define SACC_BIP_FS_LO    16'h8000
// configuration word layout
`define SACC_CFG_W        14
`define SACC_CFG_RST      14'h3FFF
`define SACC_CFG_INCC_HI  12
`define SACC_CFG_INCC_LO  10
`define SACC_INCC_SE_GND  3'b111
`define SACC_INCC_UNI_COM 3'b110
`define SACC_INCC_BIP_COM 3'b010
// timing
`define SACC_CLK_MHZ      50
`define SACC_RATE_KSPS    250
`define SACC_PERIOD_CYC   ((`SACC_CLK_MHZ * 1000) / `SACC_RATE_KSPS)
`define SACC_CONV_DIV     4
`endif

//--- verilog/sacc_sync.v
`timescale 1ns/1ps
module sacc_sync
(
  // clock and reset
  input  wire clk,
  input  wire sys_rst,
  // level
  input  wire din,
  output wire dout
);
  reg s1_r;
  reg s2_r;

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end

  assign dout = s2_r;
endmodule

//--- verilog/sacc_coder.v
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_coder
(
  // raw straight-binary code and mode
  input  wire [15:0] raw_code,
  input  wire        bipolar,
  // coded result
  output wire [15:0] code
);
  // flipping the msb maps offset binary onto twos complement, so the
  // unipolar extremes land on the bipolar saturation codes
  assign code = bipolar ? {~raw_code[15], raw_code[14:0]} : raw_code;
endmodule

//--- verilog/sacc_ctrl.v
`timescale 1ns/1ps
`include "sacc_map.vh"
module sacc_ctrl
#(
  parameter CONV_DIV = `SACC_CONV_DIV,
  parameter NBITS    = 16
)
(
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // host pins
  input  wire        conversion_start_input,
  input  wire        sck,
  input  wire        sdi,
  output reg         sdo,
  // analog model: sample as code, comparator result
  input  wire [15:0] sample_level,
  output reg  [15:0] dac_trial,
  input  wire        comp_high,
  // status
  output reg         busy,
  output reg         powered_down,
  output reg  [13:0] cfg_active,
  output reg         sample_hold,
  output reg         conv_overrun
);
  localparam ST_ACQ  = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_DONE = 2'd2;

  wire cnv_s;
  wire sck_s;
  wire sdi_s;

  sacc_sync u_sync_cnv
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (conversion_start_input),
    .dout    (cnv_s)
  );
  sacc_sync u_sync_sck
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (sck),
    .dout    (sck_s)
  );
  sacc_sync u_sync_sdi
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (sdi),
    .dout    (sdi_s)
  );

  // last divider count of one bit step, and the minimum start spacing
  localparam [7:0]  DIV_LAST = CONV_DIV - 1;
  localparam [11:0] PERIOD   = `SACC_PERIOD_CYC;

  reg        cnv_d_r;
  reg        sck_d_r;
  reg [1:0]  settle_r;
  reg [1:0]  state_r;
  reg [3:0]  bit_r;
  reg [7:0]  div_r;
  reg [15:0] sar_r;
  reg [13:0] cfg_res_r;
  reg [13:0] cfg_sh_r;
  reg [4:0]  cfg_cnt_r;
  reg [29:0] out_sh_r;
  reg [11:0] gap_r;

  // edges count only once the synchronisers hold real pin levels;
  // a pin idling high would otherwise fake an edge after reset
  wire edges_ok  = (settle_r == 2'd3);
  wire cnv_rise  = edges_ok & cnv_s & ~cnv_d_r;
  wire sck_rise  = edges_ok & sck_s & ~sck_d_r;
  wire sck_fall  = edges_ok & ~sck_s & sck_d_r;
  wire conv_tick = (div_r == DIV_LAST);
  wire [15:0] coded;

  function is_bipolar;
    input [2:0] incc;
    begin
      is_bipolar = (incc == `SACC_INCC_BIP_COM) || (incc[2:1] == 2'b00);
    end
  endfunction

  wire [2:0] incc_res = cfg_res_r[`SACC_CFG_INCC_HI:`SACC_CFG_INCC_LO];

  // result coder: sar code is mapped to twos complement when incc selects bipolar
  sacc_coder u_coder
  (
    .raw_code (sar_r),
    .bipolar  (is_bipolar(incc_res)),
    .code     (coded)
  );

  always @*
  begin
    dac_trial = sar_r | (16'h0001 << bit_r);
  end

  // edge detectors and their settling count
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnv_d_r  <= 1'b0;
      sck_d_r  <= 1'b0;
      settle_r <= 2'd0;
    end
    else
    begin
      cnv_d_r <= cnv_s;
      sck_d_r <= sck_s;
      if (!edges_ok)
        settle_r <= settle_r + 2'd1;
    end
  end

  // start spacing is only watched: a fast start in ST_ACQ is still converted,
  // the host learns from the flag that the result may be degraded
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      gap_r        <= 12'h000;
      conv_overrun <= 1'b0;
    end
    else if (cnv_rise && state_r == ST_ACQ)
    begin
      conv_overrun <= (gap_r != 12'h000);
      gap_r        <= PERIOD;
    end
    else if (gap_r != 12'h000)
      gap_r <= gap_r - 12'h001;
  end

  // config word captured on rising sck, msb first
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_sh_r   <= 14'h0000;
      cfg_cnt_r  <= 5'h00;
      cfg_active <= `SACC_CFG_RST;
    end
    else
    begin
      if (sck_rise)
      begin
        cfg_sh_r <= {cfg_sh_r[12:0], sdi_s};
        if (cfg_cnt_r == 5'd13)
        begin
          cfg_active <= {cfg_sh_r[12:0], sdi_s};
          cfg_cnt_r  <= 5'd0;
        end
        else
          cfg_cnt_r <= cfg_cnt_r + 5'd1;
      end
      // a start realigns the word count, so a broken write cannot
      // leave the next one shifted by a bit
      if (cnv_rise)
        cfg_cnt_r <= 5'd0;
    end
  end

  // conversion sequencer and result shifter
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r      <= ST_ACQ;
      bit_r        <= 4'hF;
      div_r        <= 8'h00;
      sar_r        <= 16'h0000;
      cfg_res_r    <= `SACC_CFG_RST;
      out_sh_r     <= 30'h0000_0000;
      busy         <= 1'b0;
      powered_down <= 1'b1;
      sample_hold  <= 1'b0;
      sdo          <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ACQ:
        begin
          if (cnv_rise)
          begin
            state_r      <= ST_CONV;
            sample_hold  <= 1'b1;
            busy         <= 1'b1;
            powered_down <= 1'b0;
            bit_r        <= 4'hF;
            div_r        <= 8'h00;
            sar_r        <= 16'h0000;
            // config in force at the start edge belongs to this result
            cfg_res_r    <= cfg_active;
          end
        end
        ST_CONV:
        begin
          div_r <= conv_tick ? 8'h00 : div_r + 8'h01;
          if (conv_tick)
          begin
            // keep trial bit when the sample is at or above it
            if (!comp_high)
              sar_r <= dac_trial;
            if (bit_r == 4'h0)
              state_r <= ST_DONE;
            else
              bit_r <= bit_r - 4'h1;
          end
        end
        ST_DONE:
        begin
          out_sh_r     <= {coded, cfg_res_r};
          sdo          <= coded[15];
          busy         <= 1'b0;
          sample_hold  <= 1'b0;
          powered_down <= 1'b1;
          state_r      <= ST_ACQ;
        end
        default:
          state_r <= ST_ACQ;
      endcase
      // result shifts on falling sck, readable during next conversion;
      // a fall in the load cycle is lost, the load takes priority
      if (sck_fall && state_r != ST_DONE)
      begin
        out_sh_r <= {out_sh_r[28:0], 1'b0};
        sdo      <= out_sh_r[28];
      end
    end
  end
endmodule

//--- sim/sacc_cmp_model.sv
`timescale 1ns/1ps
module sacc_cmp_model
(
  // trial code and held input
  input  wire [15:0] dac_trial,
  input  wire [15:0] sample_level,
  // decision
  output wire        comp_high
);
  assign comp_high = dac_trial > sample_level;
endmodule

//--- sim/sacc_checker.sv
`timescale 1ns/1ps
module sacc_checker
(
  // controller pins
  input wire        clk,
  input wire        sys_rst,
  input wire        conversion_start_input,
  input wire        busy,
  input wire        powered_down,
  input wire        sample_hold,
  input wire [15:0] dac_trial,
  input wire [13:0] cfg_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_busy: assert property (
    $rose(conversion_start_input) && !busy |-> ##[1:5] busy) else $error("lost");
  a_hold_conv: assert property (
    $rose(busy) |-> ##[0:1] sample_hold) else $error("no hold");
  a_first_trial: assert property (
    $rose(busy) |-> ##[0:2] dac_trial == 16'h8000) else $error("msb");
  a_busy_len: assert property (
    $rose(busy) |-> ##64 busy ##1 !busy) else $error("busy length");
  a_hold_end: assert property (
    $fell(busy) |-> ##[0:1] !sample_hold) else $error("hold stuck");
  a_pd_conv: assert property (
    $rose(busy) |-> ##[0:1] !powered_down) else $error("asleep");
  a_pd_idle: assert property (
    $fell(busy) |-> ##[0:2] powered_down) else $error("awake");
  a_rst_cfg: assert property (
    $fell(sys_rst) |-> cfg_active == 14'h3FFF) else $error("cfg");
  c_start: cover property ($rose(busy));
  c_done: cover property ($fell(busy));
  c_sleep: cover property ($rose(powered_down));
endmodule

//--- sim/sacc_ctrl_tb_top.sv
`timescale 1ns/1ps
module sacc_ctrl_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        st = 1'b0, sck = 1'b1, sdi = 1'b0;
  logic [15:0] sample_level = 16'h0000;
  logic [15:0] d;
  wire  [15:0] dac_trial;
  wire  [13:0] cfg_active;
  wire         sdo, comp_high, busy, powered_down, sample_hold, conv_overrun;
  int          n_mismatch = 0, n_checks = 0;
  // incc, input level, expected code
  logic [34:0] rows [8] = '{35'h7_8000_8000, 35'h6_FFFF_FFFF,
    35'h5_0000_0000, 35'h2_8000_0000, 35'h0_FFFF_7FFF,
    35'h1_0000_8000, 35'h4_8001_8001, 35'h2_7FFF_FFFF};
  sacc_ctrl dut (.clk, .sys_rst, .conversion_start_input(st), .sck, .sdi,
    .sdo, .sample_level, .dac_trial, .comp_high, .busy, .powered_down,
    .cfg_active, .sample_hold, .conv_overrun);
  sacc_cmp_model u_cmp (.dac_trial, .sample_level, .comp_high);
  initial forever #10 clk = ~clk;
  function automatic logic [13:0] cf(int i);
    return {1'b1, rows[i][34:32], 10'h000};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wb(input logic v);
    repeat (300) if (busy !== v) @(posedge clk);
    chk({15'h0, busy}, {15'h0, v});
    if (busy !== v) end_of_test;
  endtask
  // sck idles high; config bits ride the rises, result bits the falls
  task automatic xfer(input logic [13:0] c, output logic [15:0] r);
    for (int i = 15; i >= 0; i--)
    begin
      r[i] = sdo;
      sck <= 1'b0;
      sdi <= (i > 1) ? c[i-2] : 1'b0;
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({1'b0, powered_down, cfg_active}, 16'h7FFF);
    $display("reset done");
    xfer(cf(0), d);
    for (int k = 0; k < 8; k++)
    begin
      chk({2'h0, cfg_active}, {2'h0, cf(k)});
      sample_level <= rows[k][31:16];
      st <= 1'b1;
      wb(1'b1);
      chk({15'h0, conv_overrun}, 16'h0000);
      wb(1'b0);
      st <= 1'b0;
      repeat (2) @(posedge clk);
      xfer(cf((k + 1) % 8), d);
      // keeps starts more than one sample period apart
      repeat (8) @(posedge clk);
      chk(d, rows[k][15:0]);
      $display("row %0d done", k);
    end
    // a start while busy is ignored, the conversion runs on
    sample_level <= 16'h1234;
    st <= 1'b1;
    wb(1'b1);
    chk({15'h0, conv_overrun}, 16'h0000);
    st <= 1'b0;
    repeat (8) @(posedge clk);
    st <= 1'b1;
    wb(1'b0);
    $display("overlap done");
    // a deliberately early start is converted but flagged
    st <= 1'b0;
    repeat (4) @(posedge clk);
    st <= 1'b1;
    wb(1'b1);
    chk({15'h0, conv_overrun}, 16'h0001);
    wb(1'b0);
    repeat (2) @(posedge clk);
    xfer(cf(0), d);
    chk(d, 16'h1234);
    $display("overrun done");
    end_of_test;
  end
endmodule
bind sacc_ctrl sacc_checker u_chk (.clk, .sys_rst, .conversion_start_input,
  .busy, .powered_down, .sample_hold, .dac_trial, .cfg_active);
